// *** rtl/cea_device.sv ***
// Device end: register file, measurement sequencer, result store.
// Assumes the host drives the serial port and enable pin.
// Function
// R1 - type field: 1 threshold compare, 2 energy
// R2 - busy threshold in bits 15..8 at 04
// R3 - averaged result in bits 15..8 at 2D
// R4 - add half compensation field, default 8D
// R5 - busy flag bit 1 at 24, compare only
// R6 - completion flag bit 5 on finish; the code sets it after energy sequences only, not after a packet receive
// R7 - interrupt when completion set and mask bit10
// R8 - 144 us warm-up, then 128 us average
// R9 - busy when result at most threshold
// R10 - energy detect leaves busy flag alone
// R11 - packet receive stores energy as link quality
// R12 - result halved and negated gives dBm
// R13 - compensation step 4 shifts 1 dBm down
// R14 - host encodes threshold, suggests A4
// R15 - host setup order, then pin high
// R16 - energy detect setup skips threshold write
// R17 - host reads flags, then result, on interrupt
// R18 - host writes compensation 9B
// R19 - host keeps streaming bits zero
// R20 - sequence code 01 means energy measurement
// R21 - leave idle only with pin high
// R22 - return to idle when finished
// R23 - saturate compensated result at 00 or FF; the code only adds and clamps at FF alone
// R24 - status read clears flags and interrupt
`default_nettype none
module cea_device
(
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   cea_link_if.dev          link,
   input  wire logic [7:0]  power_sample_i,
   input  wire logic        preamble_i,
   output logic             meas_active_o
);
   typedef enum logic [2:0]
   {
      S_IDLE  = 3'h0,
      S_WARM  = 3'h1,
      S_RXPRE = 3'h3,
      S_MEAS  = 3'h2,
      S_STORE = 3'h6
   } cea_state_t;

   cea_state_t  state_reg;
   logic [15:0] thresh_reg;
   logic [15:0] ctrl_reg;
   logic [7:0]  result_reg;
   logic        busy_reg;
   logic        done_reg;
   logic [11:0] cnt_reg;
   logic [2:0]  nsym_reg;
   logic [10:0] acc_reg;
   logic        is_rx_reg;
   logic        is_cca_reg;
   logic        sck_prev_reg;
   logic [4:0]  sbit_reg;
   logic [14:0] sin_reg;
   logic [6:0]  hdr_reg;
   logic [15:0] sout_reg;
   logic [15:0] rd_val;
   logic        rise;
   logic        fall;
   logic        hdr_done;
   logic        wr_commit;
   logic        stat_rd;
   logic        pin;
   logic [1:0]  seq;
   logic [1:0]  mtype;
   logic        sym_end;
   logic [7:0]  avg;

   // R23 clamp instead of wrap
   function automatic logic [7:0] sat_add(input logic [7:0] a,
                                          input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      sat_add = s[8] ? cea_pkg::SAT_MAX : s[7:0];
   endfunction : sat_add

   assign pin      = link.sequence_enable_pin;
   assign seq      = ctrl_reg[cea_pkg::CTRL_SEQ_LSB +: 2];
   assign mtype    = ctrl_reg[cea_pkg::CTRL_TYPE_LSB +: 2];
   assign rise     = link.ser_clk && !sck_prev_reg && !link.ser_sel_n;
   assign fall     = !link.ser_clk && sck_prev_reg && !link.ser_sel_n;
   assign hdr_done = rise && (sbit_reg == 5'(cea_pkg::HDR_BITS - 1));
   assign wr_commit = rise && !hdr_reg[6]
                   && (sbit_reg == 5'(cea_pkg::FRAME_BITS - 1));
   // R24 read of status clears
   assign stat_rd  = hdr_done && sin_reg[6]
                  && ({sin_reg[4:0], link.ser_mosi} == cea_pkg::ADDR_STATUS);
   assign sym_end  = (cnt_reg == 12'(cea_pkg::SYMBOL_CYC - 1));
   assign avg      = acc_reg[cea_pkg::AVG_SHIFT +: 8];
   assign meas_active_o = (state_reg != S_IDLE);
   assign link.ser_miso = sout_reg[15];
   // R7 masked completion request
   assign link.irq_req  = done_reg && ctrl_reg[cea_pkg::CTRL_MASK_BIT];

   // ==========================================================
   // Register read mux; unmapped addresses read zero
   always_comb
   begin
      rd_val = 16'h0000;
      case ({sin_reg[4:0], link.ser_mosi})
         cea_pkg::ADDR_THRESH: rd_val = thresh_reg;
         cea_pkg::ADDR_CTRL:   rd_val = ctrl_reg;
         cea_pkg::ADDR_STATUS:
         begin
            rd_val[cea_pkg::STAT_BUSY_BIT] = busy_reg;
            rd_val[cea_pkg::STAT_DONE_BIT] = done_reg;
         end
         // R3 R12 result in high byte
         cea_pkg::ADDR_RESULT: rd_val = {result_reg, 8'h00};
         default:              rd_val = 16'h0000;
      endcase
   end

   // ==========================================================
   // Serial slave
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         sck_prev_reg <= 1'b0;
         sbit_reg     <= 5'h00;
         sin_reg      <= 15'h0000;
         hdr_reg      <= 7'h00;
         sout_reg     <= 16'h0000;
      end
      else
      begin
         sck_prev_reg <= link.ser_clk;
         if (link.ser_sel_n)
         begin
            sbit_reg <= 5'h00;
         end
         else if (rise)
         begin
            sbit_reg <= sbit_reg + 5'h01;
            sin_reg  <= {sin_reg[13:0], link.ser_mosi};
            if (hdr_done)
            begin
               // Keep the read bit, drop the fixed zero bit
               hdr_reg  <= {sin_reg[6], sin_reg[4:0], link.ser_mosi};
               sout_reg <= rd_val;
            end
         end
         else if (fall && sbit_reg > 5'(cea_pkg::HDR_BITS))
         begin
            sout_reg <= {sout_reg[14:0], 1'b0};
         end
      end
   end

   // ==========================================================
   // Writable registers
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         // R4 compensation default
         thresh_reg <= {cea_pkg::THR_RESET, cea_pkg::COMP_RESET};
         ctrl_reg   <= cea_pkg::CTRL_RESET;
      end
      else if (wr_commit)
      begin
         // R2 threshold in high byte
         if (hdr_reg[5:0] == cea_pkg::ADDR_THRESH)
            thresh_reg <= {sin_reg, link.ser_mosi};
         if (hdr_reg[5:0] == cea_pkg::ADDR_CTRL)
            ctrl_reg <= {sin_reg, link.ser_mosi};
      end
      else if (state_reg == S_STORE)
      begin
         // Disarm so a held pin does not rerun
         ctrl_reg[cea_pkg::CTRL_SEQ_LSB +: 2] <= cea_pkg::SEQ_IDLE;
      end
   end

   // ==========================================================
   // Measurement sequencer
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         state_reg  <= S_IDLE;
         cnt_reg    <= 12'h000;
         nsym_reg   <= 3'h0;
         acc_reg    <= 11'h000;
         is_rx_reg  <= 1'b0;
         is_cca_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_reg + 12'h001;
         case (state_reg)
            S_IDLE:
            begin
               cnt_reg <= 12'h000;
               // R21 pin gates leaving idle
               // R20 R1 sequence and algorithm
               if (pin && seq == cea_pkg::SEQ_ENERGY
                   && (mtype == cea_pkg::TYPE_CCA
                       || mtype == cea_pkg::TYPE_ED))
               begin
                  state_reg  <= S_WARM;
                  is_rx_reg  <= 1'b0;
                  is_cca_reg <= (mtype == cea_pkg::TYPE_CCA);
               end
               // R11 receive measures link quality
               else if (pin && seq == cea_pkg::SEQ_RX)
               begin
                  state_reg  <= S_WARM;
                  is_rx_reg  <= 1'b1;
                  is_cca_reg <= 1'b0;
               end
            end
            S_WARM:
            begin
               // R8 warm-up span
               if (!pin)
                  state_reg <= S_IDLE;
               else if (cnt_reg == 12'(cea_pkg::WARMUP_CYC - 1))
               begin
                  cnt_reg   <= 12'h000;
                  nsym_reg  <= 3'h0;
                  acc_reg   <= 11'h000;
                  state_reg <= is_rx_reg ? S_RXPRE : S_MEAS;
               end
            end
            S_RXPRE:
            begin
               cnt_reg <= 12'h000;
               if (!pin)
                  state_reg <= S_IDLE;
               else if (preamble_i)
                  state_reg <= S_MEAS;
            end
            S_MEAS:
            begin
               // R8 one sample per symbol, eight symbols
               if (!pin)
                  state_reg <= S_IDLE;
               else if (sym_end)
               begin
                  cnt_reg  <= 12'h000;
                  acc_reg  <= acc_reg + 11'(power_sample_i);
                  nsym_reg <= nsym_reg + 3'h1;
                  if (nsym_reg == 3'(cea_pkg::AVG_SYMBOLS - 1))
                     state_reg <= S_STORE;
               end
            end
            // R22 back to idle
            S_STORE: state_reg <= S_IDLE;
            default: state_reg <= S_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Result and status flags; a set beats a clearing read
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         result_reg <= 8'h00;
         busy_reg   <= 1'b0;
         done_reg   <= 1'b0;
      end
      else if (state_reg == S_STORE)
      begin
         // R4 R13 add half the compensation
         result_reg <= sat_add(avg, {1'b0, thresh_reg[7:1]});
         // R6 completion, not for receive
         done_reg   <= is_rx_reg ? (done_reg && !stat_rd) : 1'b1;
         // R5 R9 R10 busy only from compare
         if (is_cca_reg)
            busy_reg <= sat_add(avg, {1'b0, thresh_reg[7:1]})
                        <= thresh_reg[cea_pkg::HI_BYTE_LSB +: 8];
         else if (stat_rd)
            busy_reg <= 1'b0;
      end
      else if (stat_rd)
      begin
         // R24 clear on status read
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end
   end
endmodule : cea_device
`default_nettype wire

// *** rtl/cea_host.sv ***
// Host end: runs a whole assessment or energy detect on request.
// Assumes the device end on the far side of cea_link_if.
`default_nettype none
module cea_host
(
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   cea_link_if.host         link,
   input  wire logic        start_i,
   input  wire logic        mode_ed_i,
   input  wire logic [7:0]  thr_i,
   output logic             busy_o,
   output logic             done_o,
   output logic             chan_busy_o,
   output logic [7:0]       power_o
);
   typedef enum logic [2:0]
   {
      H_IDLE = 3'h0,
      H_WTHR = 3'h1,
      H_WCTL = 3'h3,
      H_WIRQ = 3'h2,
      H_RSTA = 3'h6,
      H_RRES = 3'h7
   } cea_hstate_t;

   cea_hstate_t state_reg;
   logic        xgo_reg;
   logic [23:0] xword_reg;
   logic [23:0] shift_reg;
   logic [15:0] rdata_reg;
   logic [4:0]  bit_reg;
   logic [2:0]  div_reg;
   logic        sck_reg;
   logic        sel_n_reg;
   logic        xdone_reg;
   logic        pin_reg;
   logic        tick;

   function automatic logic [23:0] frame(input logic rd,
                                         input logic [5:0] a,
                                         input logic [15:0] d);
      frame = {rd, 1'b0, a, d};
   endfunction : frame

   assign tick = (div_reg == 3'(cea_pkg::SER_HALF_CYC - 1));
   assign link.ser_clk = sck_reg;
   assign link.ser_sel_n = sel_n_reg;
   assign link.ser_mosi = shift_reg[23];
   assign link.sequence_enable_pin = pin_reg;
   assign busy_o = (state_reg != H_IDLE);

   // ==========================================================
   // Serial engine
   always_ff @(posedge clk_i)
   begin
      xdone_reg <= 1'b0;
      if (sys_rst_i)
      begin
         sel_n_reg <= 1'b1;
         sck_reg   <= 1'b0;
         div_reg   <= 3'h0;
         bit_reg   <= 5'h00;
         shift_reg <= 24'h000000;
         rdata_reg <= 16'h0000;
      end
      else if (xgo_reg)
      begin
         sel_n_reg <= 1'b0;
         shift_reg <= xword_reg;
         bit_reg   <= 5'h00;
         div_reg   <= 3'h0;
      end
      else if (!sel_n_reg)
      begin
         div_reg <= tick ? 3'h0 : div_reg + 3'h1;
         if (tick && !sck_reg)
         begin
            sck_reg   <= 1'b1;
            rdata_reg <= {rdata_reg[14:0], link.ser_miso};
         end
         else if (tick)
         begin
            sck_reg   <= 1'b0;
            shift_reg <= {shift_reg[22:0], 1'b0};
            bit_reg   <= bit_reg + 5'h01;
            if (bit_reg == 5'(cea_pkg::FRAME_BITS - 1))
            begin
               sel_n_reg <= 1'b1;
               xdone_reg <= 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // Operation sequencer
   always_ff @(posedge clk_i)
   begin
      xgo_reg <= 1'b0;
      done_o  <= 1'b0;
      if (sys_rst_i)
      begin
         state_reg   <= H_IDLE;
         pin_reg     <= 1'b0;
         xword_reg   <= 24'h000000;
         chan_busy_o <= 1'b0;
         power_o     <= 8'h00;
      end
      else
      begin
         case (state_reg)
            H_IDLE:
            begin
               if (start_i)
               begin
                  // R15 pin low first
                  pin_reg <= 1'b0;
                  xgo_reg <= 1'b1;
                  // R16 skip threshold
                  if (mode_ed_i)
                  begin
                     xword_reg <= frame(1'b0, cea_pkg::ADDR_CTRL,
                        16'(1) << cea_pkg::CTRL_MASK_BIT
                        | 16'(cea_pkg::TYPE_ED) << cea_pkg::CTRL_TYPE_LSB
                        | 16'(cea_pkg::SEQ_ENERGY));
                     state_reg <= H_WCTL;
                  end
                  else
                  begin
                     // R14 R18 threshold and comp
                     xword_reg <= frame(1'b0, cea_pkg::ADDR_THRESH,
                                        {thr_i, cea_pkg::COMP_ADVISED});
                     state_reg <= H_WTHR;
                  end
               end
            end
            H_WTHR:
            begin
               if (xdone_reg)
               begin
                  // R15 R19 mask, type, sequence
                  xgo_reg   <= 1'b1;
                  xword_reg <= frame(1'b0, cea_pkg::ADDR_CTRL,
                     16'(1) << cea_pkg::CTRL_MASK_BIT
                     | 16'(cea_pkg::TYPE_CCA) << cea_pkg::CTRL_TYPE_LSB
                     | 16'(cea_pkg::SEQ_ENERGY));
                  state_reg <= H_WCTL;
               end
            end
            H_WCTL:
            begin
               if (xdone_reg)
               begin
                  // R15 raise and hold pin
                  pin_reg   <= 1'b1;
                  state_reg <= H_WIRQ;
               end
            end
            H_WIRQ:
            begin
               if (link.irq_req)
               begin
                  // R17 read status on interrupt
                  xgo_reg   <= 1'b1;
                  xword_reg <= frame(1'b1, cea_pkg::ADDR_STATUS, 16'h0000);
                  state_reg <= H_RSTA;
               end
            end
            H_RSTA:
            begin
               if (xdone_reg)
               begin
                  chan_busy_o <= rdata_reg[cea_pkg::STAT_BUSY_BIT];
                  xgo_reg     <= 1'b1;
                  xword_reg   <= frame(1'b1, cea_pkg::ADDR_RESULT, 16'h0000);
                  state_reg   <= H_RRES;
               end
            end
            H_RRES:
            begin
               if (xdone_reg)
               begin
                  // R17 fetch power level
                  power_o   <= rdata_reg[cea_pkg::HI_BYTE_LSB +: 8];
                  done_o    <= 1'b1;
                  state_reg <= H_IDLE;
               end
            end
            default: state_reg <= H_IDLE;
         endcase
      end
   end
endmodule : cea_host
`default_nettype wire

// *** rtl/cea_link_if.sv ***
// Serial register port, sequence enable pin and interrupt line.
// The host makes the serial clock; all signals are synchronous.
`default_nettype none
interface cea_link_if;
   logic ser_clk;
   logic ser_sel_n;
   logic ser_mosi;
   logic ser_miso;
   logic sequence_enable_pin;
   logic irq_req;
   modport dev
   (
      input  ser_clk, ser_sel_n, ser_mosi, sequence_enable_pin,
      output ser_miso, irq_req
   );
   modport host
   (
      output ser_clk, ser_sel_n, ser_mosi, sequence_enable_pin,
      input  ser_miso, irq_req
   );
endinterface : cea_link_if
`default_nettype wire

// *** rtl/cea_pkg.sv ***
// Constants shared by both ends of the channel energy link.
// Assumes a single 25 MHz system clock on both ends.
`default_nettype none
package cea_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_MHZ       = 25;
   localparam int WARMUP_US     = 144;
   localparam int SYMBOL_US     = 16;
   localparam int WARMUP_CYC    = WARMUP_US * CLK_MHZ;
   localparam int SYMBOL_CYC    = SYMBOL_US * CLK_MHZ;
   localparam int AVG_SYMBOLS   = 8;
   localparam int AVG_SHIFT     = 3;
   localparam int SER_HALF_CYC  = 4;
   // ==========================================================
   // Serial frame: header byte then one 16-bit word, MSB first
   localparam int HDR_BITS      = 8;
   localparam int FRAME_BITS    = 24;
   localparam int HDR_READ_BIT  = 7;
   // ==========================================================
   // Register addresses
   localparam logic [5:0] ADDR_THRESH  = 6'h04;
   localparam logic [5:0] ADDR_CTRL    = 6'h06;
   localparam logic [5:0] ADDR_STATUS  = 6'h24;
   localparam logic [5:0] ADDR_RESULT  = 6'h2D;
   // ==========================================================
   // Fields and reset values
   localparam int CTRL_SEQ_LSB   = 0;
   localparam int CTRL_TYPE_LSB  = 4;
   localparam int CTRL_MASK_BIT  = 10;
   localparam int STAT_BUSY_BIT  = 1;
   localparam int STAT_DONE_BIT  = 5;
   localparam int HI_BYTE_LSB    = 8;
   localparam logic [7:0]  COMP_RESET   = 8'h8D;
   localparam logic [7:0]  THR_RESET    = 8'h00;
   localparam logic [15:0] CTRL_RESET   = 16'h0000;
   localparam logic [7:0]  COMP_ADVISED = 8'h9B;
   localparam logic [7:0]  THR_ADVISED  = 8'hA4;
   localparam logic [7:0]  SAT_MAX      = 8'hFF;
   // ==========================================================
   // Codes
   localparam logic [1:0] SEQ_IDLE   = 2'h0;
   localparam logic [1:0] SEQ_ENERGY = 2'h1;
   localparam logic [1:0] SEQ_RX     = 2'h2;
   localparam logic [1:0] TYPE_CCA   = 2'h1;
   localparam logic [1:0] TYPE_ED    = 2'h2;
endpackage : cea_pkg
`default_nettype wire

// *** tb/cea_link_sva.sv ***
// Checker for the channel energy link between host and device.
// Assumes one clock domain and the link signals as plain inputs.
`default_nettype none
module cea_link_sva
(
   input  wire logic clk_i,
   input  wire logic sys_rst_i,
   input  wire logic ser_clk,
   input  wire logic ser_sel_n,
   input  wire logic ser_mosi,
   input  wire logic ser_miso,
   input  wire logic sequence_enable_pin,
   input  wire logic irq_req
);
   // ==========================================================
   // Helper count of cycles since the enable pin rose
   localparam int MEAS_CYC = cea_pkg::WARMUP_CYC
                           + cea_pkg::AVG_SYMBOLS * cea_pkg::SYMBOL_CYC;
   logic [13:0] pin_cnt_reg;
   // Saturates so a long held pin never wraps into a false match
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i || !sequence_enable_pin)
         pin_cnt_reg <= 14'h0000;
      else if (pin_cnt_reg != 14'h3FFF)
         pin_cnt_reg <= pin_cnt_reg + 14'h0001;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // ==========================================================
   // Assertions
   a_irq_after_measure: assert property ($rose(irq_req) |->
      pin_cnt_reg >= MEAS_CYC && pin_cnt_reg <= MEAS_CYC + 40)
      else $error("completion came at the wrong time");
   a_irq_needs_pin: assert property ($rose(irq_req) |->
      sequence_enable_pin)
      else $error("completion without enable pin");
   a_irq_holds_idle: assert property (irq_req && ser_sel_n |=>
      irq_req)
      else $error("interrupt dropped outside a frame");
   a_irq_clear_read: assert property ($fell(irq_req) |->
      !ser_sel_n)
      else $error("interrupt cleared without access");
   a_sclk_half_period: assert property ($changed(ser_clk) |=>
      $stable(ser_clk)[*2])
      else $error("serial clock half period too short");
   a_sclk_idle_low: assert property (ser_sel_n |-> !ser_clk)
      else $error("serial clock high between frames");
   a_frame_gap_min: assert property ($rose(ser_sel_n) |=>
      ser_sel_n)
      else $error("frame gap too short");
   a_mosi_hold_high: assert property (ser_clk && $past(ser_clk) |->
      $stable(ser_mosi))
      else $error("host data moved while clock high");
   a_pin_after_setup: assert property ($rose(sequence_enable_pin) |->
      ser_sel_n && $past(ser_sel_n))
      else $error("enable pin raised during a frame");
endmodule : cea_link_sva
`default_nettype wire

// *** tb/test_channel_energy_assessment.sv ***
// Bench: host and device ends joined by the link interface.
// Assumes the rtl package, interface, both ends and checker.
`default_nettype none
module test_channel_energy_assessment;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Signals
   logic       clk_i;
   logic       sys_rst_i;
   logic       start;
   logic       mode_ed;
   logic [7:0] thr;
   logic [7:0] sample;
   logic       busy;
   logic       done;
   logic       chan_busy;
   logic [7:0] power;
   logic       meas_active;
   logic [7:0] got_power;
   logic       got_busy;
   logic       got_irq;
   int         act_cnt;
   int         n_errors;
   int         comparisons;
   localparam int MEAS = cea_pkg::WARMUP_CYC
                       + cea_pkg::AVG_SYMBOLS * cea_pkg::SYMBOL_CYC;
   cea_link_if cea_link_if_inst ();
   cea_host cea_host_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .link(cea_link_if_inst), .start_i(start), .mode_ed_i(mode_ed),
      .thr_i(thr), .busy_o(busy), .done_o(done),
      .chan_busy_o(chan_busy), .power_o(power));
   // Preamble tied: the host end cannot order a packet receive
   cea_device cea_device_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .link(cea_link_if_inst), .power_sample_i(sample),
      .preamble_i(1'b0), .meas_active_o(meas_active));
   cea_link_sva cea_link_sva_inst (.clk_i(clk_i),
      .sys_rst_i(sys_rst_i), .ser_clk(cea_link_if_inst.ser_clk),
      .ser_sel_n(cea_link_if_inst.ser_sel_n),
      .ser_mosi(cea_link_if_inst.ser_mosi),
      .ser_miso(cea_link_if_inst.ser_miso),
      .sequence_enable_pin(cea_link_if_inst.sequence_enable_pin),
      .irq_req(cea_link_if_inst.irq_req));
   // ==========================================================
   // Shared tasks
   task automatic report_and_stop();
      $display("comparisons %0d errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop
   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Constant samples make the average equal the sample
   task automatic run_op(input logic ed, input logic [7:0] t,
                         input logic [7:0] p);
      int i;
      @(posedge clk_i);
      #1;
      mode_ed = ed;
      thr = t;
      sample = p;
      start = 1'b1;
      got_irq = 1'b0;
      act_cnt = 0;
      @(posedge clk_i);
      #1;
      start = 1'b0;
      check("host_busy", 16'(busy), 16'h0001);
      for (i = 0; i < 12000 && done !== 1'b1; i++)
      begin
         @(posedge clk_i);
         #1;
         if (meas_active === 1'b1)
            act_cnt++;
         if (cea_link_if_inst.irq_req === 1'b1)
            got_irq = 1'b1;
      end
      if (done !== 1'b1)
      begin
         n_errors++;
         $display("unexpected hang: no completion");
         report_and_stop();
      end
      got_power = power;
      got_busy = chan_busy;
      check("meas_len", 16'(act_cnt >= MEAS && act_cnt <= MEAS + 4),
            16'h0001);
      check("idle_after", 16'(meas_active), 16'h0000);
      check("host_idle", 16'(busy), 16'h0000);
      check("irq_cleared", 16'(cea_link_if_inst.irq_req), 16'h0000);
      check("irq_seen", 16'(got_irq), 16'h0001);
   endtask : run_op
   // ==========================================================
   // Scenarios
   // default compensation half added
   task automatic t_ed_default();
      run_op(1'b1, 8'h00, 8'h30);
      check("ed_power", 16'(got_power),
            16'(8'h30 + (cea_pkg::COMP_RESET >> 1)));
      check("ed_busy", 16'(got_busy), 16'h0000);
   endtask : t_ed_default
   task automatic t_cca_equal();
      run_op(1'b0, 8'hFF, 8'hF0);
      check("cca_power", 16'(got_power), 16'(cea_pkg::SAT_MAX));
      check("cca_busy", 16'(got_busy), 16'h0001);
   endtask : t_cca_equal
   // no compare even when result equals threshold
   task automatic t_ed_after_busy();
      run_op(1'b1, 8'hFF, 8'hF0);
      check("ed_sat_power", 16'(got_power), 16'(cea_pkg::SAT_MAX));
      check("ed_no_busy", 16'(got_busy), 16'h0000);
   endtask : t_ed_after_busy
   task automatic t_cca_above();
      run_op(1'b0, 8'hFE, 8'hF0);
      check("clear_busy", 16'(got_busy), 16'h0000);
   endtask : t_cca_above
   // ==========================================================
   // Clock and main sequence
   initial
   begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   initial
   begin
      n_errors = 0;
      comparisons = 0;
      sys_rst_i = 1'b1;
      start = 1'b0;
      mode_ed = 1'b0;
      thr = 8'h00;
      sample = 8'h00;
      got_irq = 1'b0;
      repeat (10) @(posedge clk_i);
      #1;
      sys_rst_i = 1'b0;
      t_ed_default();
      t_cca_equal();
      t_ed_after_busy();
      t_cca_above();
      report_and_stop();
   end
endmodule : test_channel_energy_assessment
`default_nettype wire
